// file: core/calibration_word_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "cwm_params.svh"

// Behaviour
// - Word: four data bits, parity bit four
// - Twelve-bit fields: low word holds lowest bits
// - Two temperature references, words 0-2, 16-18
// - Word 3 trims oscillator, 1111 fastest
// - Fine gain orders one, two signed
// - Fine offset orders one, two signed
// - Word 7 bit 0 swaps inputs
// - Word 7 bits 1-3 coarse gain
// - Coarse offset from words 11 and 15
// - Zero order gain uses ten bits
// - Zero order offset uses ten bits
// - Word 15 bit 0 enables clamping
// - Clamp low three, high three bits
// - Clamp from words 19 and 23
// - Sensor offset from words 23, 27
// - Word 23 bit 1 picks internal sensor
// - Sensor gain word 31 bits 1-3
// - Sensor gain 111 highest, 000 lowest
module calibration_word_map (
    input  wire logic        core_clk,              // 125 MHz clock
    input  wire logic        nrst,                  // Sync reset, low
    input  wire logic        cal_reload,            // Reload request pulse
    input  wire logic        prog_wr_en,            // Word write strobe
    input  wire logic        prog_rd_en,            // Word read strobe
    input  wire logic [7:0]  prog_addr,             // Word address
    input  wire logic [7:0]  prog_wdata,            // Write byte
    output logic      [7:0]  prog_rdata,            // Read byte
    output logic             prog_rvalid,           // Read byte valid
    output logic             prog_wack,             // Write taken
    output logic             prog_busy,             // Reload running
    output logic             cal_valid,             // Fields published
    output logic             parity_error,          // Parity miss seen
    output logic      [11:0] gain_temp_reference,   // Gain ref temp
    output logic      [11:0] offset_temp_reference, // Offset ref temp
    output logic      [3:0]  oscillator_trim,       // Oscillator trim
    output logic      [11:0] gain_second_order,     // Signed
    output logic      [11:0] gain_first_order,      // Signed
    output logic      [9:0]  gain_zero_order,       // Ten used bits
    output logic      [11:0] offset_second_order,   // Signed
    output logic      [11:0] offset_first_order,    // Signed
    output logic      [9:0]  offset_zero_order,     // Ten used bits
    output logic             input_swap,            // Swap sensor inputs
    output logic      [2:0]  coarse_gain_select,    // Coarse gain
    output logic      [6:0]  coarse_offset_select,  // Coarse offset
    output logic             rail_limit_enable,     // Clamp enable
    output logic      [5:0]  rail_limit_levels,     // High 5:3, low 2:0
    output logic             thermal_source_select, // 1 internal sensor
    output logic      [4:0]  thermal_sensor_offset, // Ext sensor offset
    output logic      [2:0]  thermal_sensor_gain    // Sensor gain
);
    // ==========================================================
    // Declarations
    cwm_pkg::cwm_state_t state_reg;
    logic [4:0]          cnt_reg;
    cwm_pkg::cwm_nib_t   nib_reg [0:31];
    logic                addr_ok;
    logic                wr_take;
    logic                rd_take;
    logic                par_bad;

    cwm_store_if st_if ();

    cwm_word_store u_store (
        .core_clk (core_clk),
        .st       (st_if.mem)
    );

    // ==========================================================
    // Store port: loader owns it while busy
    assign addr_ok = (prog_addr[7:6] == 2'h0);
    assign wr_take = prog_wr_en && !prog_busy && addr_ok;
    assign rd_take = prog_rd_en && !prog_busy;

    assign st_if.we    = wr_take;
    assign st_if.wdata = prog_wdata[4:0];
    assign st_if.addr  = prog_busy ? {1'b0, cnt_reg} : prog_addr[5:0];

    // Even parity unless the odd option is set
    assign par_bad = ((^st_if.rdata) != `CWM_PARITY_ODD);

    // ==========================================================
    // Loader sequence
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= cwm_pkg::ST_LOAD;
            cnt_reg   <= 5'h00;
            prog_busy <= 1'b1;
        end else begin
            case (state_reg)
                cwm_pkg::ST_LOAD: begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (cnt_reg == `CWM_CAL_LAST) begin
                        state_reg <= cwm_pkg::ST_PUB;
                    end
                end
                cwm_pkg::ST_PUB: begin
                    state_reg <= cwm_pkg::ST_IDLE;
                    prog_busy <= 1'b0;
                end
                default: begin
                    if (cal_reload) begin
                        state_reg <= cwm_pkg::ST_LOAD;
                        cnt_reg   <= 5'h00;
                        prog_busy <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Shadow nibbles: outputs only change at publish
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                nib_reg[i] <= `CWM_RST_NIB;
            end
        end else if (state_reg == cwm_pkg::ST_LOAD) begin
            nib_reg[cnt_reg] <= st_if.rdata[3:0];
        end
    end

    // Parity check over every loaded word, rearmed per load
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            parity_error <= 1'b0;
        end else if (state_reg == cwm_pkg::ST_LOAD) begin
            if (cnt_reg == 5'h00) begin
                parity_error <= par_bad;
            end else if (par_bad) begin
                parity_error <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Programmer word access
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prog_rdata  <= `CWM_RST_BYTE;
            prog_rvalid <= 1'b0;
            prog_wack   <= 1'b0;
        end else begin
            prog_rvalid <= rd_take;
            prog_wack   <= wr_take;
            if (rd_take) begin
                // Upper three bits always zero; out of range reads zero
                prog_rdata <= addr_ok ? {3'h0, st_if.rdata} : `CWM_RST_BYTE;
            end
        end
    end

    // ==========================================================
    // Field assembly at publish
    // Valid drops one edge after a reload is taken, once busy is up
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cal_valid <= 1'b0;
        end else if (state_reg == cwm_pkg::ST_PUB) begin
            cal_valid <= 1'b1;
        end else if (state_reg == cwm_pkg::ST_LOAD) begin
            cal_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gain_temp_reference   <= 12'h000;
            offset_temp_reference <= 12'h000;
            oscillator_trim       <= 4'h0;
            gain_second_order     <= 12'h000;
            gain_first_order      <= 12'h000;
            gain_zero_order       <= 10'h000;
            offset_second_order   <= 12'h000;
            offset_first_order    <= 12'h000;
            offset_zero_order     <= 10'h000;
            input_swap            <= 1'b0;
            coarse_gain_select    <= 3'h0;
            coarse_offset_select  <= 7'h00;
            rail_limit_enable     <= 1'b0;
            rail_limit_levels     <= 6'h00;
            thermal_source_select <= 1'b0;
            thermal_sensor_offset <= 5'h00;
            thermal_sensor_gain   <= 3'h0;
        end else if (state_reg == cwm_pkg::ST_PUB) begin
            gain_temp_reference   <= {nib_reg[`CWM_A_GTREF+5'd2], nib_reg[`CWM_A_GTREF+5'd1],
                                      nib_reg[`CWM_A_GTREF]};
            offset_temp_reference <= {nib_reg[`CWM_A_OTREF+5'd2], nib_reg[`CWM_A_OTREF+5'd1],
                                      nib_reg[`CWM_A_OTREF]};
            // Word bit 0 carries the trim MSB
            oscillator_trim       <= {<<{nib_reg[`CWM_A_OSC]}};
            gain_second_order     <= {nib_reg[`CWM_A_G2+5'd2], nib_reg[`CWM_A_G2+5'd1],
                                      nib_reg[`CWM_A_G2]};
            gain_first_order      <= {nib_reg[`CWM_A_G1+5'd2], nib_reg[`CWM_A_G1+5'd1],
                                      nib_reg[`CWM_A_G1]};
            // Top two stored bits dropped, programmer keeps them zero
            gain_zero_order       <= {nib_reg[`CWM_A_G0+5'd2][1:0], nib_reg[`CWM_A_G0+5'd1],
                                      nib_reg[`CWM_A_G0]};
            offset_second_order   <= {nib_reg[`CWM_A_O2+5'd2], nib_reg[`CWM_A_O2+5'd1],
                                      nib_reg[`CWM_A_O2]};
            offset_first_order    <= {nib_reg[`CWM_A_O1+5'd2], nib_reg[`CWM_A_O1+5'd1],
                                      nib_reg[`CWM_A_O1]};
            offset_zero_order     <= {nib_reg[`CWM_A_O0+5'd2][1:0], nib_reg[`CWM_A_O0+5'd1],
                                      nib_reg[`CWM_A_O0]};
            input_swap            <= nib_reg[`CWM_A_CGSW][`CWM_B_SWAP];
            coarse_gain_select    <= {nib_reg[`CWM_A_CGSW][1], nib_reg[`CWM_A_CGSW][2],
                                      nib_reg[`CWM_A_CGSW][3]};
            coarse_offset_select  <= {nib_reg[`CWM_A_CLMP_COFS][1], nib_reg[`CWM_A_CLMP_COFS][2],
                                      nib_reg[`CWM_A_CLMP_COFS][3],
                                      nib_reg[`CWM_A_COFS_LO][0], nib_reg[`CWM_A_COFS_LO][1],
                                      nib_reg[`CWM_A_COFS_LO][2], nib_reg[`CWM_A_COFS_LO][3]};
            rail_limit_enable     <= nib_reg[`CWM_A_CLMP_COFS][`CWM_B_CLAMP_EN];
            rail_limit_levels     <= {nib_reg[`CWM_A_THERM_MIX][2], nib_reg[`CWM_A_THERM_MIX][3],
                                      nib_reg[`CWM_A_RAIL_LO][0], nib_reg[`CWM_A_RAIL_LO][1],
                                      nib_reg[`CWM_A_RAIL_LO][2], nib_reg[`CWM_A_RAIL_LO][3]};
            thermal_source_select <= nib_reg[`CWM_A_THERM_MIX][`CWM_B_TSEL];
            // Inverted sense: all ones gives the lowest pin voltage
            thermal_sensor_offset <= {nib_reg[`CWM_A_TOFS_HI][0], nib_reg[`CWM_A_TOFS_HI][1],
                                      nib_reg[`CWM_A_TOFS_HI][2], nib_reg[`CWM_A_TOFS_HI][3],
                                      nib_reg[`CWM_A_THERM_MIX][`CWM_B_TOFS0]};
            // Bit 0 of this word is ignored
            thermal_sensor_gain   <= {nib_reg[`CWM_A_TGAIN][1], nib_reg[`CWM_A_TGAIN][2],
                                      nib_reg[`CWM_A_TGAIN][3]};
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_byte_top_zero;
        prog_rd_en && !prog_busy |=> prog_rvalid && (prog_rdata[7:5] == 3'h0);
    endproperty
    a_byte_top_zero: assert property (p_byte_top_zero) else $error("read byte top bits set");

    property p_word_order;
        state_reg == cwm_pkg::ST_PUB |=> gain_first_order[3:0] == nib_reg[8]
            && gain_first_order[7:4] == nib_reg[9] && gain_first_order[11:8] == nib_reg[10];
    endproperty
    a_word_order: assert property (p_word_order) else $error("multi-word order wrong");

    property p_two_refs;
        state_reg == cwm_pkg::ST_PUB |=> gain_temp_reference == {nib_reg[2], nib_reg[1], nib_reg[0]}
            && offset_temp_reference == {nib_reg[18], nib_reg[17], nib_reg[16]};
    endproperty
    a_two_refs: assert property (p_two_refs) else $error("temperature reference wrong");

    property p_osc_trim;
        state_reg == cwm_pkg::ST_PUB |=> oscillator_trim[3] == nib_reg[3][0]
            && oscillator_trim[0] == nib_reg[3][3];
    endproperty
    a_osc_trim: assert property (p_osc_trim) else $error("oscillator trim wrong");

    property p_gain_sign;
        state_reg == cwm_pkg::ST_PUB |=> ($signed(gain_second_order) < 0) == nib_reg[6][3]
            && ($signed(gain_first_order) < 0) == nib_reg[10][3];
    endproperty
    a_gain_sign: assert property (p_gain_sign) else $error("gain sign wrong");

    property p_offset_sign;
        state_reg == cwm_pkg::ST_PUB |=> ($signed(offset_second_order) < 0) == nib_reg[22][3]
            && ($signed(offset_first_order) < 0) == nib_reg[26][3];
    endproperty
    a_offset_sign: assert property (p_offset_sign) else $error("offset sign wrong");

    property p_swap_cg;
        state_reg == cwm_pkg::ST_PUB |=> input_swap == nib_reg[7][0]
            && coarse_gain_select == {nib_reg[7][1], nib_reg[7][2], nib_reg[7][3]};
    endproperty
    a_swap_cg: assert property (p_swap_cg) else $error("swap or coarse gain wrong");

    property p_coarse_ofs;
        state_reg == cwm_pkg::ST_PUB |=> coarse_offset_select[6] == nib_reg[15][1]
            && coarse_offset_select[3] == nib_reg[11][0] && coarse_offset_select[0] == nib_reg[11][3];
    endproperty
    a_coarse_ofs: assert property (p_coarse_ofs) else $error("coarse offset wrong");

    property p_zero_orders;
        state_reg == cwm_pkg::ST_PUB |=> gain_zero_order[9:8] == nib_reg[14][1:0]
            && offset_zero_order[9:8] == nib_reg[30][1:0] && offset_zero_order[3:0] == nib_reg[28];
    endproperty
    a_zero_orders: assert property (p_zero_orders) else $error("zero order wrong");

    property p_clamp;
        state_reg == cwm_pkg::ST_PUB |=> rail_limit_enable == nib_reg[15][0]
            && rail_limit_levels[5:4] == {nib_reg[23][2], nib_reg[23][3]}
            && rail_limit_levels[3] == nib_reg[19][0];
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp fields wrong");

    property p_thermal;
        state_reg == cwm_pkg::ST_PUB |=> thermal_source_select == nib_reg[23][1]
            && thermal_sensor_offset == {nib_reg[27][0], nib_reg[27][1], nib_reg[27][2],
                                         nib_reg[27][3], nib_reg[23][0]};
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal select or offset wrong");

    property p_tgain;
        state_reg == cwm_pkg::ST_PUB |=> thermal_sensor_gain == {nib_reg[31][1], nib_reg[31][2], nib_reg[31][3]};
    endproperty
    a_tgain: assert property (p_tgain) else $error("sensor gain wrong");

    property p_load_len;
        state_reg == cwm_pkg::ST_LOAD && cnt_reg == 5'h00 |-> ##32 state_reg == cwm_pkg::ST_PUB ##1 cal_valid;
    endproperty
    a_load_len: assert property (p_load_len) else $error("reload length wrong");

    property p_hold;
        state_reg == cwm_pkg::ST_IDLE && $past(state_reg) == cwm_pkg::ST_IDLE
            |-> $stable(gain_first_order) && $stable(rail_limit_levels) && $stable(oscillator_trim);
    endproperty
    a_hold: assert property (p_hold) else $error("fields moved between reloads");

    property p_parity_flag;
        state_reg == cwm_pkg::ST_LOAD && par_bad |=> parity_error;
    endproperty
    a_parity_flag: assert property (p_parity_flag) else $error("parity miss not flagged");

    // Store port belongs to the loader while busy
    property p_busy_quiet;
        prog_busy |=> !prog_wack && !prog_rvalid;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("access answered during reload");

    property p_far_read;
        prog_rd_en && !prog_busy && (prog_addr[7:6] != 2'h0) |=> prog_rvalid && (prog_rdata == 8'h00);
    endproperty
    a_far_read: assert property (p_far_read) else $error("out of range read not zero");

    c_load_done: cover property (state_reg == cwm_pkg::ST_PUB ##1 cal_valid);
    c_read:      cover property (prog_rd_en && !prog_busy ##1 prog_rvalid);
    c_write:     cover property (prog_wack);
    c_reload:    cover property (state_reg == cwm_pkg::ST_IDLE && cal_reload);
    c_parity:    cover property (state_reg == cwm_pkg::ST_PUB && parity_error);
endmodule : calibration_word_map

`default_nettype wire

// file: core/cwm_params.svh
`ifndef CWM_PARAMS_SVH
`define CWM_PARAMS_SVH

// ==========================================================
// Word store geometry
`define CWM_WORDS        64
`define CWM_CAL_LAST     5'd31
`define CWM_PAR_BIT      4
`define CWM_PARITY_ODD   1'b0

// ==========================================================
// Word offsets of each field
`define CWM_A_GTREF      5'h00
`define CWM_A_OSC        5'h03
`define CWM_A_G2         5'h04
`define CWM_A_CGSW       5'h07
`define CWM_A_G1         5'h08
`define CWM_A_COFS_LO    5'h0b
`define CWM_A_G0         5'h0c
`define CWM_A_CLMP_COFS  5'h0f
`define CWM_A_OTREF      5'h10
`define CWM_A_RAIL_LO    5'h13
`define CWM_A_O2         5'h14
`define CWM_A_THERM_MIX  5'h17
`define CWM_A_O1         5'h18
`define CWM_A_TOFS_HI    5'h1b
`define CWM_A_O0         5'h1c
`define CWM_A_TGAIN      5'h1f

// ==========================================================
// Bit positions inside a word
`define CWM_B_SWAP       0
`define CWM_B_CLAMP_EN   0
`define CWM_B_TOFS0      0
`define CWM_B_TSEL       1

// ==========================================================
// Reset values
`define CWM_RST_NIB      4'h0
`define CWM_RST_BYTE     8'h00
`define CWM_BLANK_WORD   5'h00

`endif

// file: core/cwm_pkg.sv
package cwm_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_PUB
    } cwm_state_t;

    typedef logic [4:0] cwm_word_t;
    typedef logic [3:0] cwm_nib_t;
endpackage : cwm_pkg

// file: core/cwm_store_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cwm_store_if;
    logic              we;
    logic [5:0]        addr;
    cwm_pkg::cwm_word_t wdata;
    cwm_pkg::cwm_word_t rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface : cwm_store_if

`default_nettype wire

// file: core/cwm_word_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "cwm_params.svh"

module cwm_word_store (
    input  wire logic core_clk, // Core clock
    cwm_store_if.mem  st        // Word port
);
    // Nonvolatile contents: deliberately not cleared by reset
    // Erased image at power-up so a first reload never reads unknown words
    cwm_pkg::cwm_word_t mem_reg [0:`CWM_WORDS-1] = '{default: `CWM_BLANK_WORD};

    always_ff @(posedge core_clk) begin
        if (st.we) begin
            mem_reg[st.addr] <= st.wdata;
        end
    end

    assign st.rdata = mem_reg[st.addr];
endmodule : cwm_word_store

`default_nettype wire

// file: testbench/calibration_word_map_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module calibration_word_map_tb;
    // Arbitrary stand-in for the factory oscillator trim
    localparam logic [3:0] FACTORY_TRIM = 4'hc;
    localparam int         TIMEOUT_CYC  = 20000;

    logic        core_clk;
    logic        nrst;
    logic        cal_reload;
    logic        prog_wr_en;
    logic        prog_rd_en;
    logic [7:0]  prog_addr;
    logic [7:0]  prog_wdata;
    logic [7:0]  prog_rdata;
    logic        prog_rvalid;
    logic        prog_wack;
    logic        prog_busy;
    logic        cal_valid;
    logic        parity_error;
    logic [11:0] gain_temp_reference;
    logic [11:0] offset_temp_reference;
    logic [3:0]  oscillator_trim;
    logic [11:0] gain_second_order;
    logic [11:0] gain_first_order;
    logic [9:0]  gain_zero_order;
    logic [11:0] offset_second_order;
    logic [11:0] offset_first_order;
    logic [9:0]  offset_zero_order;
    logic        input_swap;
    logic [2:0]  coarse_gain_select;
    logic [6:0]  coarse_offset_select;
    logic        rail_limit_enable;
    logic [5:0]  rail_limit_levels;
    logic        thermal_source_select;
    logic [4:0]  thermal_sensor_offset;
    logic [2:0]  thermal_sensor_gain;
    int          err_count;
    int          checks_done;
    int          cycles;

    calibration_word_map calibration_word_map_inst (
        .core_clk(core_clk), .nrst(nrst), .cal_reload(cal_reload),
        .prog_wr_en(prog_wr_en), .prog_rd_en(prog_rd_en), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
        .prog_wack(prog_wack), .prog_busy(prog_busy), .cal_valid(cal_valid),
        .parity_error(parity_error), .gain_temp_reference(gain_temp_reference),
        .offset_temp_reference(offset_temp_reference), .oscillator_trim(oscillator_trim),
        .gain_second_order(gain_second_order), .gain_first_order(gain_first_order),
        .gain_zero_order(gain_zero_order), .offset_second_order(offset_second_order),
        .offset_first_order(offset_first_order), .offset_zero_order(offset_zero_order),
        .input_swap(input_swap), .coarse_gain_select(coarse_gain_select),
        .coarse_offset_select(coarse_offset_select), .rail_limit_enable(rail_limit_enable),
        .rail_limit_levels(rail_limit_levels), .thermal_source_select(thermal_source_select),
        .thermal_sensor_offset(thermal_sensor_offset), .thermal_sensor_gain(thermal_sensor_gain)
    );

    // ==========================================================
    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge core_clk);
            cycles++;
            if (cycles >= TIMEOUT_CYC) begin
                err_count++;
                end_of_test();
            end
        end
    end

    // ==========================================================
    // Stimulus helpers
    function automatic logic [3:0] nib(input int i, input int p);
        logic [3:0] v;
        v = 4'(i * 5 + 3);
        if (p != 0) v = ~v;
        if (i == 3) v = FACTORY_TRIM;
        if (i == 14 || i == 30) v = v & 4'h3;
        return v;
    endfunction : nib

    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
        prog_wr_en = 1'b1;
        prog_addr  = a;
        prog_wdata = d;
        @(negedge core_clk);
        `CHK(prog_wack, exp_ack)
        // Idle edge so back-to-back calls never retoggle the strobe in one step
        prog_wr_en = 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        prog_rd_en = 1'b1;
        prog_addr  = a;
        @(negedge core_clk);
        `CHK(prog_rvalid, 1'b1)
        `CHK(prog_rdata, exp)
        prog_rd_en = 1'b0;
        @(negedge core_clk);
    endtask : rd

    // Even parity; upper bits are junk the store must drop
    task automatic wr_word(input int i, input int p, input logic [2:0] junk);
        wr(8'(i), {junk, ^nib(i, p), nib(i, p)}, 1'b1);
    endtask : wr_word

    // A write attempted mid-reload must be ignored
    task automatic reload();
        int n;
        n = 0;
        cal_reload = 1'b1;
        // Valid is still high from the last publish for one edge
        while (n < 100 && (n < 2 || cal_valid !== 1'b1)) begin
            @(negedge core_clk);
            n++;
            cal_reload = 1'b0;
            if (n == 2) `CHK({prog_busy, cal_valid}, 2'b10)
            if (n == 5) prog_wr_en = 1'b1;
            if (n == 6) begin
                prog_wr_en = 1'b0;
                `CHK(prog_wack, 1'b0)
            end
        end
        `CHK(n, 34)
    endtask : reload

    task automatic check_fields(input int p);
        logic [3:0] w [0:31];
        for (int i = 0; i < 32; i++) w[i] = nib(i, p);
        `CHK(gain_temp_reference, {w[2], w[1], w[0]})
        `CHK(offset_temp_reference, {w[18], w[17], w[16]})
        `CHK(oscillator_trim, rev4(w[3]))
        `CHK(gain_second_order, {w[6], w[5], w[4]})
        `CHK(gain_first_order, {w[10], w[9], w[8]})
        `CHK(gain_zero_order, {w[14][1:0], w[13], w[12]})
        `CHK(offset_second_order, {w[22], w[21], w[20]})
        `CHK(offset_first_order, {w[26], w[25], w[24]})
        `CHK(offset_zero_order, {w[30][1:0], w[29], w[28]})
        `CHK(input_swap, w[7][0])
        `CHK(coarse_gain_select, {w[7][1], w[7][2], w[7][3]})
        `CHK(coarse_offset_select, {w[15][1], w[15][2], w[15][3], rev4(w[11])})
        `CHK(rail_limit_enable, w[15][0])
        `CHK(rail_limit_levels, {w[23][2], w[23][3], rev4(w[19])})
        `CHK(thermal_source_select, w[23][1])
        `CHK(thermal_sensor_offset, {rev4(w[27]), w[23][0]})
        `CHK(thermal_sensor_gain, {w[31][1], w[31][2], w[31][3]})
        `CHK(parity_error, 1'b0)
    endtask : check_fields

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    initial begin
        err_count   = 0;
        checks_done = 0;
        nrst        = 1'b0;
        cal_reload  = 1'b0;
        prog_wr_en  = 1'b0;
        prog_rd_en  = 1'b0;
        prog_addr   = 8'h00;
        prog_wdata  = 8'h1f;
        repeat (8) @(negedge core_clk);
        `CHK({prog_busy, cal_valid}, 2'b10)
        nrst = 1'b1;
        repeat (40) @(negedge core_clk);
        `CHK({prog_busy, cal_valid}, 2'b01)
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 32; i++) wr_word(i, p, 3'(p * 7));
            if (p > 0) check_fields(p - 1);
            reload();
            check_fields(p);
            for (int i = 0; i < 32; i++) rd(8'(i), {3'b000, ^nib(i, p), nib(i, p)});
        end
        wr(8'h40, 8'h00, 1'b0);
        rd(8'h45, 8'h00);
        wr(8'h05, {4'h1, nib(5, 1)}, 1'b1);
        rd(8'h05, {4'h1, nib(5, 1)});
        reload();
        `CHK(parity_error, ^{4'h1, nib(5, 1)})
        wr_word(5, 1, 3'b000);
        reload();
        check_fields(1);
        end_of_test();
    end
endmodule : calibration_word_map_tb

`undef CHK

`default_nettype wire
